// file: include/cbr_defs.vh
/*
 * Constants for the upper configuration register bank of the
 * clock buffer: register indices, field positions, reset values.
 * Assumes inclusion by bare name from rtl files.
 */
`ifndef CBR_DEFS_VH
`define CBR_DEFS_VH

// -----------------------------------------------------------------
// register indices
// -----------------------------------------------------------------
`define CBR_IDX_FSEL 8'h03
`define CBR_IDX_RSVD 8'h04
`define CBR_IDX_REV 8'h05
`define CBR_IDX_DEV 8'h06
`define CBR_IDX_LEN 8'h07

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CBR_FSEL_EN_BIT 5
`define CBR_FSEL_HI_BIT 4
`define CBR_FSEL_LO_BIT 3
`define CBR_FB_RATE_BIT 0
`define CBR_LEN_MSB 4
`define CBR_RW_MASK_FSEL 8'h39
`define CBR_RSVD_FSEL 8'h46

// -----------------------------------------------------------------
// reset values and fixed reads
// -----------------------------------------------------------------
`define CBR_RST_FSEL 8'h01
`define CBR_RST_LEN 5'h08
`define CBR_RST_FSEL_EN 1'b0
`define CBR_RST_FB_RATE 1'b1
`define CBR_RSVD_BYTE 8'hFF
`define CBR_ZERO_BYTE 8'h00
`define CBR_FSEL_OFF 2'h0

// -----------------------------------------------------------------
// smbus framing
// -----------------------------------------------------------------
`define CBR_LAST_BIT 3'h7
`define CBR_BNO_INDEX 2'h0
`define CBR_BNO_COUNT 2'h1
`define CBR_BNO_DATA 2'h2

`endif

// file: rtl/cbr_regs.v
/*
 * Register bank for bytes 3 to 7: storage, fixed fields and read mux.
 * Assumes writes arrive as single-cycle strobes from the bus engine.
 */
`timescale 1ns/1ps
`include "cbr_defs.vh"

module cbr_regs #(
   parameter [3:0] REV_CODE = 4'h2,  // arbitrary value
   parameter [3:0] MAKER_CODE = 4'h5,  // arbitrary value
   parameter [1:0] CATEGORY_CODE = 2'h2,  // arbitrary value
   parameter [5:0] PART_ID = 6'h15  // arbitrary value
) (
   input wire ref_clk,
   input wire rst_n,
   input wire wr_en,
   input wire [7:0] wr_idx,
   input wire [7:0] wr_data,
   input wire [7:0] rd_idx,
   output reg [7:0] rd_data,
   output wire fsel_en,
   output wire [1:0] fsel_field,
   output wire fb_rate,
   output wire [4:0] read_len
);

   reg [7:0] fsel_r;
   reg [4:0] len_r;

   // -----------------------------------------------------------------
   // writable storage
   // -----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fsel_r <= `CBR_RST_FSEL;
         len_r <= `CBR_RST_LEN;
      end else if (wr_en) begin
         if (wr_idx == `CBR_IDX_FSEL) begin
            fsel_r <= wr_data & `CBR_RW_MASK_FSEL;
         end
         if (wr_idx == `CBR_IDX_LEN) begin
            len_r <= wr_data[`CBR_LEN_MSB:0];
         end
      end
   end

   assign fsel_en = fsel_r[`CBR_FSEL_EN_BIT];
   assign fsel_field = {fsel_r[`CBR_FSEL_HI_BIT], fsel_r[`CBR_FSEL_LO_BIT]};
   assign fb_rate = fsel_r[`CBR_FB_RATE_BIT];
   assign read_len = len_r;

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   always @* begin
      case (rd_idx)
         `CBR_IDX_FSEL: rd_data = fsel_r | `CBR_RSVD_FSEL;
         `CBR_IDX_RSVD: rd_data = `CBR_RSVD_BYTE;
         `CBR_IDX_REV: rd_data = {REV_CODE, MAKER_CODE};
         `CBR_IDX_DEV: rd_data = {CATEGORY_CODE, PART_ID};
         `CBR_IDX_LEN: rd_data = {3'h0, len_r};
         default: rd_data = `CBR_ZERO_BYTE;
      endcase
   end

endmodule // cbr_regs

// file: rtl/cbr_top.v
/*
 * SMBus slave for the upper configuration bank of the clock buffer,
 * with block write and block read, plus registered control outputs.
 * Assumes scl and sda inputs are already synchronous to ref_clk and
 * that the bus runs far slower than ref_clk.
 */
`timescale 1ns/1ps
`include "cbr_defs.vh"

// Summary of operation
// - byte 3 bit 5 enables software frequency change
// - frequency select acts only while enable set
// - byte 3 bit 0 feedback edge rate, default fast
// - byte 4 reads all ones
// - byte 5 fixed revision and maker code
// - byte 6 fixed category and part identifier
// - byte 7 five-bit read length, default eight
// - block read sends count then data bytes
module cbr_top (
   input wire ref_clk,
   input wire rst_n,
   input wire [6:0] slave_addr,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out_r,
   output reg sda_oe_r,
   output reg freq_sw_enable_r,
   output reg [1:0] frequency_choice_r,
   output reg feedback_edge_rate_select_r,
   output reg [4:0] readback_length_r
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_ACK_TX = 3'h2;
   localparam [2:0] ST_RX = 3'h3;
   localparam [2:0] ST_TX = 3'h4;
   localparam [2:0] ST_ACK_RX = 3'h5;

   reg scl_q_r;
   reg sda_q_r;
   reg [2:0] st_r;
   reg [2:0] bit_cnt_r;
   reg [7:0] shreg_r;
   reg byte_done_r;
   reg [1:0] byte_no_r;
   reg [7:0] ptr_r;
   reg rw_r;
   reg first_tx_r;
   reg host_ack_r;
   reg wr_en_r;
   reg [7:0] wr_idx_r;
   reg [7:0] wr_data_r;

   wire [7:0] rd_data;
   wire fsel_en;
   wire [1:0] fsel_field;
   wire fb_rate;
   wire [4:0] read_len;

   wire scl_rise = scl_in & ~scl_q_r;
   wire scl_fall = ~scl_in & scl_q_r;
   wire start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
   wire stop_det = scl_in & scl_q_r & ~sda_q_r & sda_in;
   wire [7:0] count_byte = {3'h0, read_len};

   // -----------------------------------------------------------------
   // register bank
   // -----------------------------------------------------------------
   cbr_regs u_regs (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(wr_en_r),
      .wr_idx(wr_idx_r),
      .wr_data(wr_data_r),
      .rd_idx(ptr_r),
      .rd_data(rd_data),
      .fsel_en(fsel_en),
      .fsel_field(fsel_field),
      .fb_rate(fb_rate),
      .read_len(read_len)
   );

   // -----------------------------------------------------------------
   // registered control outputs
   // -----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_sw_enable_r <= `CBR_RST_FSEL_EN;
         frequency_choice_r <= `CBR_FSEL_OFF;
         feedback_edge_rate_select_r <= `CBR_RST_FB_RATE;
         readback_length_r <= `CBR_RST_LEN;
      end else begin
         freq_sw_enable_r <= fsel_en;
         frequency_choice_r <= fsel_en ? fsel_field : `CBR_FSEL_OFF;
         feedback_edge_rate_select_r <= fb_rate;
         readback_length_r <= read_len;
      end
   end

   // -----------------------------------------------------------------
   // smbus engine
   // -----------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         st_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         shreg_r <= 8'h00;
         byte_done_r <= 1'b0;
         byte_no_r <= `CBR_BNO_INDEX;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         first_tx_r <= 1'b0;
         host_ack_r <= 1'b0;
         wr_en_r <= 1'b0;
         wr_idx_r <= 8'h00;
         wr_data_r <= 8'h00;
         sda_out_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
         wr_en_r <= 1'b0;
         if (stop_det) begin
            st_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
         end else if (start_det) begin
            // repeated start keeps the pointer for the read phase
            st_r <= ST_ADDR;
            bit_cnt_r <= 3'h0;
            byte_done_r <= 1'b0;
            byte_no_r <= `CBR_BNO_INDEX;
            sda_oe_r <= 1'b0;
         end else begin
            case (st_r)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shreg_r <= {shreg_r[6:0], sda_in};
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == `CBR_LAST_BIT) begin
                        byte_done_r <= 1'b1;
                     end
                  end else if (scl_fall && byte_done_r) begin
                     byte_done_r <= 1'b0;
                     if (st_r == ST_ADDR) begin
                        if (shreg_r[7:1] == slave_addr) begin
                           rw_r <= shreg_r[0];
                           first_tx_r <= shreg_r[0];
                           sda_oe_r <= 1'b1;
                           st_r <= ST_ACK_TX;
                        end else begin
                           st_r <= ST_IDLE;
                        end
                     end else begin
                        sda_oe_r <= 1'b1;
                        st_r <= ST_ACK_TX;
                        case (byte_no_r)
                           `CBR_BNO_INDEX: begin
                              ptr_r <= shreg_r;
                              byte_no_r <= `CBR_BNO_COUNT;
                           end
                           `CBR_BNO_COUNT: begin
                              byte_no_r <= `CBR_BNO_DATA;
                           end
                           default: begin
                              wr_en_r <= 1'b1;
                              wr_idx_r <= ptr_r;
                              wr_data_r <= shreg_r;
                              ptr_r <= ptr_r + 8'h01;
                           end
                        endcase
                     end
                  end
               end
               ST_ACK_TX: begin
                  if (scl_fall) begin
                     bit_cnt_r <= 3'h0;
                     if (rw_r) begin
                        // count first, then data from the pointer
                        first_tx_r <= 1'b0;
                        if (first_tx_r) begin
                           shreg_r <= {count_byte[6:0], 1'b0};
                           sda_oe_r <= ~count_byte[7];
                        end else begin
                           shreg_r <= {rd_data[6:0], 1'b0};
                           sda_oe_r <= ~rd_data[7];
                           ptr_r <= ptr_r + 8'h01;
                        end
                        st_r <= ST_TX;
                     end else begin
                        sda_oe_r <= 1'b0;
                        st_r <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == `CBR_LAST_BIT) begin
                        sda_oe_r <= 1'b0;
                        st_r <= ST_ACK_RX;
                     end else begin
                        sda_oe_r <= ~shreg_r[7];
                        shreg_r <= {shreg_r[6:0], 1'b0};
                     end
                  end
               end
               ST_ACK_RX: begin
                  if (scl_rise) begin
                     host_ack_r <= ~sda_in;
                  end else if (scl_fall) begin
                     bit_cnt_r <= 3'h0;
                     if (host_ack_r) begin
                        shreg_r <= {rd_data[6:0], 1'b0};
                        sda_oe_r <= ~rd_data[7];
                        ptr_r <= ptr_r + 8'h01;
                        st_r <= ST_TX;
                     end else begin
                        st_r <= ST_IDLE;
                     end
                  end
               end
               ST_IDLE: begin
                  sda_oe_r <= 1'b0;
               end
               default: begin
                  st_r <= ST_IDLE;
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // cbr_top

// file: tb/cbr_props_properties.sv
/* assertions on the cbr_top ports
   assumes one clock domain; bound below */
`timescale 1ns/1ps
module cbr_props (
   input wire ref_clk,
   input wire rst_n,
   input wire scl_in,
   input wire sda_out_r,
   input wire sda_oe_r,
   input wire freq_sw_enable_r,
   input wire [1:0] frequency_choice_r,
   input wire feedback_edge_rate_select_r,
   input wire [4:0] readback_length_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   reg [3:0] hi_r;
   wire [3:0] sel = {freq_sw_enable_r, frequency_choice_r,
      feedback_edge_rate_select_r};
   // scl high time, saturating
   always @(posedge ref_clk or negedge rst_n)
      if (!rst_n) hi_r <= 4'h0;
      else hi_r <= scl_in ? hi_r + {3'h0, ~&hi_r} : 4'h0;
   sequence s_low2;
      !scl_in && !$past(scl_in);
   endsequence
   a_choice_gated: assert property (
      !freq_sw_enable_r |-> frequency_choice_r == 2'h0) else $error("gate");
   a_open_drain: assert property (
      sda_out_r == 1'b0) else $error("sda high");
   a_reset_vals: assert property (
      $rose(rst_n) |-> sel == 4'h1 && readback_length_r == 5'h08)
      else $error("reset value");
   a_oe_scl_low: assert property (
      $changed(sda_oe_r) |-> s_low2) else $error("oe timing");
   a_cfg_scl_low: assert property (
      $changed({sel, readback_length_r}) |-> s_low2) else $error("cfg");
   a_sel_settle: assert property (
      $changed(sel) |=> $stable(sel) [*8]) else $error("sel toggle");
   a_len_settle: assert property (
      $changed(readback_length_r) |=> $stable(readback_length_r) [*8])
      else $error("len toggle");
   a_idle_free: assert property (
      hi_r >= 4'h8 |-> !sda_oe_r) else $error("idle drive");
endmodule // cbr_props

bind cbr_top cbr_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .scl_in(scl_in), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
   .freq_sw_enable_r(freq_sw_enable_r),
   .frequency_choice_r(frequency_choice_r),
   .feedback_edge_rate_select_r(feedback_edge_rate_select_r),
   .readback_length_r(readback_length_r));

// file: tb/cbr_host.sv
/* smbus host model: block writes and block reads
   assumes sda_w is the wired line with a pull-up */
`timescale 1ns/1ps
module cbr_host (
   input wire ref_clk,
   input wire sda_w,
   output reg scl,
   output reg sda_h
);
   reg [7:0] rx [0:7];
   reg [7:0] q;
   reg nack, k;
   integer j;
   initial scl = 1'b1;
   initial sda_h = 1'b1;
   task tk(input integer n);
      repeat (n) @(negedge ref_clk);
   endtask
   // one scl period; b differs from a only for start or stop
   task ph(input a, input b, output r);
      begin
         scl = 1'b0;
         tk(2);
         sda_h = a;
         tk(3);
         scl = 1'b1;
         tk(2);
         r = sda_w;
         tk(1);
         sda_h = b;
         tk(2);
      end
   endtask
   task bytex(input [7:0] d, input a, output [7:0] o);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            ph(d[i], d[i], o[i]);
         ph(a, a, k);
      end
   endtask
   task wr(input [6:0] ad, input [7:0] ix, input [7:0] n,
      input [15:0] dt);
      begin
         ph(1'b1, 1'b0, k);
         bytex({ad, 1'b0}, 1'b1, q);
         nack = k;
         bytex(ix, 1'b1, q);
         bytex(n, 1'b1, q);
         for (j = 0; j < n; j = j + 1)
            bytex(dt[15 - 8 * j -: 8], 1'b1, q);
         ph(1'b0, 1'b1, k);
      end
   endtask
   task rd(input [6:0] ad, input [7:0] ix, input integer n);
      begin
         ph(1'b1, 1'b0, k);
         bytex({ad, 1'b0}, 1'b1, q);
         bytex(ix, 1'b1, q);
         ph(1'b1, 1'b0, k);
         bytex({ad, 1'b1}, 1'b1, q);
         for (j = 0; j <= n; j = j + 1)
            bytex(8'hff, j == n, rx[j]);
         ph(1'b0, 1'b1, k);
      end
   endtask
endmodule // cbr_host

// file: tb/tb_top.sv
/* self-checking bench for cbr_top
   assumes the cbr_host model and the bound checker */
`timescale 1ns/1ps
module tb_top;
   localparam [6:0] ADDR = 7'h2a; // arbitrary bus address
   localparam [7:0] ID5 = 8'h25; // arbitrary identity default
   localparam [7:0] ID6 = 8'h95; // arbitrary identity default
   // rows: index, write data, read back, {en, choice, rate, length}
   localparam [260:0] ROWS = {
      4'h3, 8'hff, 8'h7f, 9'h1e8, 4'h3, 8'h00, 8'h46, 9'h008,
      4'h3, 8'h18, 8'h5e, 9'h008, 4'h3, 8'h29, 8'h6f, 9'h168,
      4'h4, 8'h00, 8'hff, 9'h168, 4'h5, 8'h00, ID5, 9'h168,
      4'h6, 8'h00, ID6, 9'h168, 4'h7, 8'hff, 8'h1f, 9'h17f,
      4'h7, 8'h03, 8'h03, 9'h163};
   reg ref_clk;
   reg rst_n;
   reg [28:0] r;
   wire scl, sda_h, sda_out_r, sda_oe_r, en, rate;
   wire [1:0] ch;
   wire [4:0] len;
   wire sda_w = sda_h & (sda_oe_r ? sda_out_r : 1'b1);
   wire [8:0] ctl = {en, ch, rate, len};
   wire [39:0] dfl = {8'h47, 8'hff, ID5, ID6, 8'h08};
   integer n_errors, n_tests, i;
   cbr_host host (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl),
      .sda_h(sda_h));
   cbr_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .slave_addr(ADDR),
      .scl_in(scl), .sda_in(sda_w), .sda_out_r(sda_out_r),
      .sda_oe_r(sda_oe_r), .freq_sw_enable_r(en),
      .frequency_choice_r(ch), .feedback_edge_rate_select_r(rate),
      .readback_length_r(len));
   task chk(input [8:0] seen, input [8:0] exp, input [63:0] nm);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task rst_chk;
      begin
         rst_n = 1'b0;
         repeat (5) @(negedge ref_clk);
         rst_n = 1'b1;
         chk(ctl, 9'h028, "rst_ctl");
         host.tk(2);
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_errors = n_errors + 1;
      summarize;
   end
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      n_errors = 0;
      n_tests = 0;
      rst_chk;
      host.rd(ADDR, 8'h03, 5);
      chk(host.rx[0], 8'h08, "count");
      for (i = 1; i < 6; i = i + 1)
         chk(host.rx[i], dfl[47 - 8 * i -: 8], "dflt");
      $display("test defaults done");
      for (i = 0; i < 9; i = i + 1) begin
         r = ROWS[29 * (8 - i) +: 29];
         host.wr(ADDR, {4'h0, r[28:25]}, 8'h01, {r[24:17], 8'h00});
         host.rd(ADDR, {4'h0, r[28:25]}, 1);
         chk(host.rx[1], r[16:9], "rd_byte");
         chk(ctl, r[8:0], "ctl");
         $display("row %0d done", i);
      end
      host.wr(ADDR, 8'h06, 8'h02, 16'h0005);
      host.rd(ADDR, 8'h05, 3);
      chk(host.rx[0], 8'h05, "count");
      chk(host.rx[2], ID6, "id6");
      chk(host.rx[3], 8'h05, "len_rd");
      host.rd(ADDR, 8'h10, 1);
      chk(host.rx[1], 8'h00, "unmapped");
      host.wr(ADDR ^ 7'h01, 8'h07, 8'h01, 16'h1f00);
      chk(host.nack, 1'b1, "nack");
      chk(len, 5'h05, "len_keep");
      $display("test edges done");
      host.tk(12);
      rst_chk;
      $display("test reset done");
      summarize;
   end
endmodule // tb_top
